// >>> design/hspc_counter.sv
// single-channel high-speed pulse counter with period count and
// two count-triggered outputs
// assumes field inputs already synchronous to clk; no register bus
`default_nettype none

module hspc_counter #(
  parameter int unsigned WINDOW_LONG_CYCLES  = hspc_pkg::WINDOW_LONG_CYCLES,
  parameter int unsigned WINDOW_SHORT_CYCLES = hspc_pkg::WINDOW_SHORT_CYCLES
) (
  // clock, reset, enable
  input  wire logic                         clk,
  input  wire logic                         resetn,
  input  wire logic                         ce,
  // field inputs
  input  wire logic                         pulseA,
  input  wire logic                         pulseB,
  input  wire logic                         indexInput,
  input  wire logic                         limitSwitch,
  // configuration
  input  wire logic [1:0]                   countingMode,
  input  wire logic                         measureWindowSelect,
  input  wire logic [hspc_pkg::COUNT_W-1:0] presetValue,
  input  wire logic                         forcePresetA,
  input  wire logic                         freezeCount,
  input  wire logic                         indexPresetEnable,
  input  wire logic                         limitPresetEnable,
  // range output setup
  input  wire logic [hspc_pkg::RANGE_N-1:0] rangeEnable,
  input  wire logic [hspc_pkg::RANGE_N-1:0][hspc_pkg::COUNT_W-1:0] rangeLow,
  input  wire logic [hspc_pkg::RANGE_N-1:0][hspc_pkg::COUNT_W-1:0] rangeHigh,
  // results
  output logic [hspc_pkg::COUNT_W-1:0]      pulseTotal,
  output logic [hspc_pkg::COUNT_W-1:0]      periodCount,
  output logic [hspc_pkg::STATUS_W-1:0]     channelInputStatus,
  output logic [hspc_pkg::RANGE_N-1:0]      rangeOutputs
);

  typedef struct packed {
    logic [hspc_pkg::COUNT_W-1:0]  count;
    logic [hspc_pkg::COUNT_W-1:0]  startCount;
    logic [hspc_pkg::COUNT_W-1:0]  periodCount;
    logic [hspc_pkg::COUNT_W-1:0]  windowCnt;
    logic                          windowSel;
    logic                          prevA;
    logic                          prevB;
    logic [hspc_pkg::STATUS_W-1:0] status;
    logic [hspc_pkg::RANGE_N-1:0]  rangeOn;
  } hspc_state_s;

  hspc_state_s                  st_reg;
  hspc_state_s                  st_next;
  logic [1:0]                   rstPipe_reg;
  logic                         rstSync;
  logic [hspc_pkg::RANGE_N-1:0] rangeOnNext;
  logic [hspc_pkg::COUNT_W-1:0] countNext;
  logic [hspc_pkg::COUNT_W-1:0] windowLen;
  logic                         windowEnd;
  logic                         anyPreset;
  logic                         riseA;
  logic                         riseB;
  hspc_pkg::hspc_step_e         step;

  // decode one quadrature transition, double changes give no step
  function automatic hspc_pkg::hspc_step_e quadStep(
    input logic [3:0] trans
  );
    hspc_pkg::hspc_step_e res;
    res = hspc_pkg::HSPC_STEP_NONE;
    if (trans == hspc_pkg::QUAD_UP_0 || trans == hspc_pkg::QUAD_UP_1 ||
        trans == hspc_pkg::QUAD_UP_2 || trans == hspc_pkg::QUAD_UP_3) begin
      res = hspc_pkg::HSPC_STEP_UP;
    end else if (trans == hspc_pkg::QUAD_DN_0 ||
                 trans == hspc_pkg::QUAD_DN_1 ||
                 trans == hspc_pkg::QUAD_DN_2 ||
                 trans == hspc_pkg::QUAD_DN_3) begin
      res = hspc_pkg::HSPC_STEP_DOWN;
    end
    return res;
  endfunction

  // reset release through two flip-flops
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rstPipe_reg <= 2'h0;
    end else begin
      rstPipe_reg <= {rstPipe_reg[0], 1'b1};
    end
  end
  assign rstSync = rstPipe_reg[1];

  // edge and preset conditions
  assign riseA     = pulseA & ~st_reg.prevA;
  assign riseB     = pulseB & ~st_reg.prevB;
  assign anyPreset = forcePresetA
                   | (indexInput & indexPresetEnable)
                   | (limitSwitch & limitPresetEnable);

  // window length and end of window
  assign windowLen = (st_reg.windowSel == hspc_pkg::WINDOW_SEL_LONG) ?
                     WINDOW_LONG_CYCLES[hspc_pkg::COUNT_W-1:0] :
                     WINDOW_SHORT_CYCLES[hspc_pkg::COUNT_W-1:0];
  assign windowEnd = (measureWindowSelect == st_reg.windowSel) &&
                     (st_reg.windowCnt == windowLen - hspc_pkg::COUNT_ONE);

  // step from the pulse inputs by counting mode; inputs at 80/160 kHz
  // change far slower than the clock so every edge is seen
  always_comb begin
    step = hspc_pkg::HSPC_STEP_NONE;
    unique case (hspc_pkg::hspc_mode_e'(countingMode))
      hspc_pkg::HSPC_MODE_PULSE_DIR: begin
        if (riseA) begin
          step = pulseB ? hspc_pkg::HSPC_STEP_DOWN : hspc_pkg::HSPC_STEP_UP;
        end
      end
      hspc_pkg::HSPC_MODE_UP_DOWN: begin
        if (riseA && !riseB) begin
          step = hspc_pkg::HSPC_STEP_UP;
        end else if (riseB && !riseA) begin
          step = hspc_pkg::HSPC_STEP_DOWN;
        end
      end
      hspc_pkg::HSPC_MODE_QUAD: begin
        step = quadStep({st_reg.prevA, st_reg.prevB,
                         pulseA, pulseB});
      end
      default: begin
        step = hspc_pkg::HSPC_STEP_NONE;
      end
    endcase
  end

  // next count apart from the state copy, so the range outputs
  // do not loop back through st_next; presets beat freeze beat steps
  always_comb begin
    countNext = st_reg.count;
    if (anyPreset) begin
      countNext = presetValue;
    end else if (!freezeCount) begin
      if (step == hspc_pkg::HSPC_STEP_UP) begin
        countNext = st_reg.count + hspc_pkg::COUNT_ONE;
      end else if (step == hspc_pkg::HSPC_STEP_DOWN) begin
        countNext = st_reg.count - hspc_pkg::COUNT_ONE;
      end
    end
  end

  // count, window and status next state
  always_comb begin
    st_next = st_reg;
    st_next.count = countNext;
    st_next.prevA = pulseA;
    st_next.prevB = pulseB;
    st_next.status[hspc_pkg::STS_A]  = pulseA;
    st_next.status[hspc_pkg::STS_B]  = pulseB;
    st_next.status[hspc_pkg::STS_Z]  = indexInput;
    st_next.status[hspc_pkg::STS_LS] = limitSwitch;
    // a changed window select restarts the window
    if (measureWindowSelect != st_reg.windowSel) begin
      st_next.windowSel  = measureWindowSelect;
      st_next.windowCnt  = hspc_pkg::COUNT_RESET;
      st_next.startCount = st_reg.count;
    end else if (windowEnd) begin
      st_next.periodCount = st_reg.count - st_reg.startCount;
      st_next.startCount  = st_reg.count;
      st_next.windowCnt   = hspc_pkg::COUNT_RESET;
    end else begin
      st_next.windowCnt = st_reg.windowCnt + hspc_pkg::COUNT_ONE;
    end
    st_next.rangeOn = rangeOnNext;
  end

  // range outputs follow the next count value
  for (genvar i = 0; i < hspc_pkg::RANGE_N; i++) begin : gRange
    hspc_range_out uRange (
      .enable     (rangeEnable[i]),
      .rangeLow   (rangeLow[i]),
      .rangeHigh  (rangeHigh[i]),
      .countValue (countNext),
      .isOn       (st_reg.rangeOn[i]),
      .onNext     (rangeOnNext[i])
    );
  end

  // state register, frozen while ce is low
  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      st_reg <= '0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state register
  assign pulseTotal         = st_reg.count;
  assign periodCount        = st_reg.periodCount;
  assign channelInputStatus = st_reg.status;
  assign rangeOutputs       = st_reg.rangeOn;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstSync);

  AST_STATUS_FOLLOW: assert property (
    ce |=> channelInputStatus == $past({limitSwitch, indexInput,
                                        pulseB, pulseA}))
    else $error("status bits do not follow inputs");

  AST_INDEX_PRESET: assert property (
    ce && indexInput && indexPresetEnable |=> pulseTotal == $past(presetValue))
    else $error("index did not load preset");

  AST_LIMIT_PRESET: assert property (
    ce && limitSwitch && limitPresetEnable |=>
      pulseTotal == $past(presetValue))
    else $error("limit switch did not load preset");

  AST_FORCE_PRESET: assert property (
    ce && forcePresetA |=> pulseTotal == $past(presetValue))
    else $error("force preset did not load preset");

  AST_FREEZE: assert property (
    ce && freezeCount && !anyPreset |=> $stable(pulseTotal))
    else $error("count moved while frozen");

  AST_PD_COUNT: assert property (
    ce && countingMode == 2'h0 && riseA && !anyPreset && !freezeCount |=>
      pulseTotal == $past(pulseB ? st_reg.count - hspc_pkg::COUNT_ONE
                                 : st_reg.count + hspc_pkg::COUNT_ONE))
    else $error("pulse and direction count wrong");

  AST_UD_DOWN: assert property (
    ce && countingMode == 2'h1 && riseB && !riseA && !anyPreset &&
    !freezeCount |=> pulseTotal == $past(st_reg.count) - hspc_pkg::COUNT_ONE)
    else $error("down pulse did not decrement");

  AST_QUAD_DOUBLE: assert property (
    ce && countingMode == 2'h2 && !anyPreset &&
    pulseA != st_reg.prevA && pulseB != st_reg.prevB |=> $stable(pulseTotal))
    else $error("double quadrature change was counted");

  AST_QUAD_UP: assert property (
    ce && countingMode == 2'h2 && !anyPreset && !freezeCount &&
    !st_reg.prevA && !st_reg.prevB && pulseA && !pulseB |=>
      pulseTotal == $past(st_reg.count) + hspc_pkg::COUNT_ONE)
    else $error("quadrature up step not counted");

  AST_PERIOD: assert property (
    ce && windowEnd |=>
      periodCount == $past(st_reg.count - st_reg.startCount))
    else $error("period count not total difference");

  AST_RANGE_ON: assert property (
    ce && rangeEnable[0] && st_next.count == rangeLow[0] &&
    st_next.count != rangeHigh[0] |=> rangeOutputs[0] ##1 !ce || $stable(
      rangeOutputs[0]) || pulseTotal != $past(pulseTotal))
    else $error("range output did not turn on at low mark");

  AST_RANGE_OFF: assert property (
    ce && st_next.count == rangeHigh[1] |=> !rangeOutputs[1])
    else $error("range output did not turn off at high mark");

  COV_QUAD_UP: cover property (ce && countingMode == 2'h2 &&
    step == hspc_pkg::HSPC_STEP_UP);
  COV_WINDOW_END: cover property (ce && windowEnd);
  COV_RANGE_ON: cover property (!rangeOutputs[0] ##1 rangeOutputs[0]);
  COV_INDEX_PRESET: cover property (ce && indexInput && indexPresetEnable);

endmodule

`default_nettype wire

// >>> design/hspc_range_out.sv
// next state of one count-triggered range output
// assumes the caller registers onNext and feeds it back as isOn
`default_nettype none

module hspc_range_out (
  // range setup
  input  wire logic                         enable,
  input  wire logic [hspc_pkg::COUNT_W-1:0] rangeLow,
  input  wire logic [hspc_pkg::COUNT_W-1:0] rangeHigh,
  // count and present state
  input  wire logic [hspc_pkg::COUNT_W-1:0] countValue,
  input  wire logic                         isOn,
  // next output level
  output logic                              onNext
);

  // off when disabled; the high mark wins when both marks match
  always_comb begin
    if (!enable) begin
      onNext = 1'b0;
    end else if (countValue == rangeHigh) begin
      onNext = 1'b0;
    end else if (countValue == rangeLow) begin
      onNext = 1'b1;
    end else begin
      onNext = isOn;
    end
  end

endmodule

`default_nettype wire

// >>> include/hspc_pkg.sv
// constants and types shared by the high-speed pulse counter
// assumes a single 100 MHz clock domain and synchronous field inputs
`default_nettype none

package hspc_pkg;

  // clock and measurement windows
  localparam int unsigned CLK_FREQ_HZ     = 100_000_000;
  localparam int unsigned MS_PER_S        = 1000;
  localparam int unsigned WINDOW_LONG_MS  = 1000;
  localparam int unsigned WINDOW_SHORT_MS = 200;
  localparam int unsigned WINDOW_LONG_CYCLES  =
    CLK_FREQ_HZ / MS_PER_S * WINDOW_LONG_MS;
  localparam int unsigned WINDOW_SHORT_CYCLES =
    CLK_FREQ_HZ / MS_PER_S * WINDOW_SHORT_MS;

  // widths and reset values
  localparam int unsigned COUNT_W  = 32;
  localparam int unsigned RANGE_N  = 2;
  localparam int unsigned STATUS_W = 4;
  localparam logic [COUNT_W-1:0] COUNT_RESET = 32'h0000_0000;
  localparam logic [COUNT_W-1:0] COUNT_ONE   = 32'h0000_0001;

  // bit positions in channelInputStatus
  localparam int unsigned STS_A  = 0;
  localparam int unsigned STS_B  = 1;
  localparam int unsigned STS_Z  = 2;
  localparam int unsigned STS_LS = 3;

  // measure_window_select encoding
  localparam logic WINDOW_SEL_LONG  = 1'h0;
  localparam logic WINDOW_SEL_SHORT = 1'h1;

  // counting_mode encoding
  typedef enum logic [1:0] {
    HSPC_MODE_PULSE_DIR = 2'h0,
    HSPC_MODE_UP_DOWN   = 2'h1,
    HSPC_MODE_QUAD      = 2'h2
  } hspc_mode_e;

  // count step decoded from the pulse inputs
  typedef enum logic [1:0] {
    HSPC_STEP_NONE = 2'h0,
    HSPC_STEP_UP   = 2'h1,
    HSPC_STEP_DOWN = 2'h2
  } hspc_step_e;

  // quadrature transitions as {prevA, prevB, curA, curB}, A leading = up
  localparam logic [3:0] QUAD_UP_0 = 4'h2;
  localparam logic [3:0] QUAD_UP_1 = 4'hB;
  localparam logic [3:0] QUAD_UP_2 = 4'hD;
  localparam logic [3:0] QUAD_UP_3 = 4'h4;
  localparam logic [3:0] QUAD_DN_0 = 4'h1;
  localparam logic [3:0] QUAD_DN_1 = 4'h7;
  localparam logic [3:0] QUAD_DN_2 = 4'hE;
  localparam logic [3:0] QUAD_DN_3 = 4'h8;

endpackage

`default_nettype wire

// >>> verif/hspc_enc_model.sv
// field-side model: encoder phases, index and limit switch lines
// assumes the bench calls its tasks; lines move at falling edges
`default_nettype none

module hspc_enc_model (
  // reference clock
  input  wire logic clk,
  // field lines, held until the next call
  output logic      pulseA,
  output logic      pulseB,
  output logic      indexInput,
  output logic      limitSwitch
);
  timeunit 1ns;
  timeprecision 1ps;

  // quadrature position, gray coded onto A and B
  logic [1:0] phase = 2'h0;

  // lines idle low before the first call
  initial begin
    {pulseA, pulseB, indexInput, limitSwitch} = 4'h0;
  end

  // set all lines at a falling edge, hold n cycles (slow source)
  task automatic drive(input logic a, input logic b, input logic z,
                       input logic ls, input int n);
    @(negedge clk);
    {pulseA, pulseB, indexInput, limitSwitch} = {a, b, z, ls};
    repeat (n - 1) @(negedge clk);
  endtask

  // one quadrature step, A leading B when counting up
  task automatic quad(input logic up, input int n);
    phase = up ? phase + 2'h1 : phase - 2'h1;
    drive(phase[1] ^ phase[0], phase[1], 1'b0, 1'b0, n);
  endtask
endmodule

`default_nettype wire

// >>> verif/tb.sv
// self-checking bench for the high-speed pulse counter
// assumes package and design compiled first; windows are shortened
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int unsigned LONG_W  = 50;
  localparam int unsigned SHORT_W = 10;

  // design inputs driven by the bench
  logic             clk = 1'b0;
  logic             resetn = 1'b0;
  logic             ce = 1'b0;
  logic [1:0]       countingMode = 2'h3;
  logic             measureWindowSelect = 1'b1;
  logic [31:0]      presetValue = 32'h0;
  logic             forcePresetA = 1'b0;
  logic             freezeCount = 1'b0;
  logic             indexPresetEnable = 1'b0;
  logic             limitPresetEnable = 1'b0;
  logic [1:0]       rangeEnable = 2'h0;
  logic [1:0][31:0] rangeLow = 64'h0;
  logic [1:0][31:0] rangeHigh = 64'h0;
  // field lines and results
  logic             pulseA;
  logic             pulseB;
  logic             indexInput;
  logic             limitSwitch;
  logic [31:0]      pulseTotal;
  logic [31:0]      periodCount;
  logic [3:0]       channelInputStatus;
  logic [1:0]       rangeOutputs;
  // bookkeeping
  logic [31:0]      expTotal = 32'h0;
  int               n_errors = 0;
  int               compares = 0;
  int               cycles = 0;

  hspc_enc_model enc (.clk(clk), .pulseA(pulseA), .pulseB(pulseB),
    .indexInput(indexInput), .limitSwitch(limitSwitch));

  hspc_counter #(.WINDOW_LONG_CYCLES(LONG_W),
    .WINDOW_SHORT_CYCLES(SHORT_W)) dut (.clk(clk), .resetn(resetn),
    .ce(ce), .pulseA(pulseA), .pulseB(pulseB), .indexInput(indexInput),
    .limitSwitch(limitSwitch), .countingMode(countingMode),
    .measureWindowSelect(measureWindowSelect), .presetValue(presetValue),
    .forcePresetA(forcePresetA), .freezeCount(freezeCount),
    .indexPresetEnable(indexPresetEnable),
    .limitPresetEnable(limitPresetEnable), .rangeEnable(rangeEnable),
    .rangeLow(rangeLow), .rangeHigh(rangeHigh), .pulseTotal(pulseTotal),
    .periodCount(periodCount), .channelInputStatus(channelInputStatus),
    .rangeOutputs(rangeOutputs));

  // 100 MHz clock and hang guard
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    if (n_errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one pulse on the chosen lines under a mode, then check the count
  task automatic step(input logic [1:0] m, input logic a, input logic b,
                      input logic [31:0] d);
    @(negedge clk);
    countingMode = m;
    enc.drive(a, b, 1'b0, 1'b0, 1);
    enc.drive(1'b0, 1'b0, 1'b0, 1'b0, 1);
    expTotal = expTotal + d;
    @(negedge clk);
    chk("pulseTotal", expTotal, pulseTotal);
  endtask

  // status follows pins; z and ls inert while their enables are off
  task automatic t_status();
    for (int v = 0; v < 16; v++) begin
      enc.drive(v[0], v[1], v[2], v[3], 1);
      @(negedge clk);
      chk("status", 32'(v), {28'h0, channelInputStatus});
    end
    // lines back low so the next pulse is a real rising edge
    enc.drive(1'b0, 1'b0, 1'b0, 1'b0, 1);
    chk("pulseTotal", expTotal, pulseTotal);
  endtask

  // every mode; all three pulse combinations in modes 0 and 1, only A and B together in mode 2, only A in mode 3
  task automatic t_modes();
    step(2'h0, 1'b1, 1'b0, 32'h1);
    step(2'h0, 1'b1, 1'b1, 32'hFFFF_FFFF);
    step(2'h0, 1'b0, 1'b1, 32'h0);
    step(2'h1, 1'b1, 1'b0, 32'h1);
    step(2'h1, 1'b0, 1'b1, 32'hFFFF_FFFF);
    step(2'h1, 1'b1, 1'b1, 32'h0);
    step(2'h2, 1'b1, 1'b1, 32'h0);
    step(2'h3, 1'b1, 1'b0, 32'h0);
  endtask

  task automatic t_quad();
    @(negedge clk);
    countingMode = 2'h2;
    repeat (6) enc.quad(1'b1, 1);
    @(negedge clk);
    expTotal = expTotal + 32'h6;
    chk("pulseTotal", expTotal, pulseTotal);
    repeat (6) enc.quad(1'b0, 3);
    expTotal = expTotal - 32'h6;
    chk("pulseTotal", expTotal, pulseTotal);
  endtask

  task automatic t_preset();
    @(negedge clk);
    presetValue = 32'h0000_1234;
    indexPresetEnable = 1'b1;
    limitPresetEnable = 1'b1;
    enc.drive(1'b0, 1'b0, 1'b1, 1'b0, 1);
    enc.drive(1'b0, 1'b0, 1'b0, 1'b1, 1);
    presetValue = 32'hFFFF_FFFF;
    chk("pulseTotal", 32'h0000_1234, pulseTotal);
    enc.drive(1'b0, 1'b0, 1'b0, 1'b0, 1);
    expTotal = 32'hFFFF_FFFF;
    chk("pulseTotal", expTotal, pulseTotal);
    step(2'h0, 1'b1, 1'b0, 32'h1);
    presetValue = 32'h0000_0100;
    forcePresetA = 1'b1;
    @(negedge clk);
    forcePresetA = 1'b0;
    freezeCount = 1'b1;
    expTotal = 32'h0000_0100;
    chk("pulseTotal", expTotal, pulseTotal);
    step(2'h0, 1'b1, 1'b0, 32'h0);
    presetValue = 32'h0000_0200;
    forcePresetA = 1'b1;
    @(negedge clk);
    forcePresetA = 1'b0;
    freezeCount = 1'b0;
    expTotal = 32'h0000_0200;
    chk("pulseTotal", expTotal, pulseTotal);
  endtask

  // output 0 on at 202 off at 204; output 1 has equal marks, stays off
  task automatic t_range();
    logic [1:0] e;
    e = 2'h0;
    rangeEnable = 2'h3;
    rangeLow = {32'h0000_0203, 32'h0000_0202};
    rangeHigh = {32'h0000_0203, 32'h0000_0204};
    for (int i = 0; i < 6; i++) begin
      step(2'h0, 1'b1, 1'b0, 32'h1);
      for (int k = 0; k < 2; k++) begin
        if (expTotal == rangeHigh[k]) e[k] = 1'b0;
        else if (expTotal == rangeLow[k]) e[k] = 1'b1;
      end
      chk("rangeOutputs", {30'h0, e}, {30'h0, rangeOutputs});
    end
  endtask

  // one up pulse every two cycles; window select chosen first
  task automatic t_window();
    int len;
    for (int s = 0; s < 2; s++) begin
      len = (s == 0) ? LONG_W : SHORT_W;
      @(negedge clk);
      countingMode = 2'h1;
      measureWindowSelect = s[0];
      repeat (len + 2) begin
        enc.drive(1'b1, 1'b0, 1'b0, 1'b0, 1);
        enc.drive(1'b0, 1'b0, 1'b0, 1'b0, 1);
        expTotal = expTotal + 32'h1;
      end
      @(negedge clk);
      chk("periodCount", 32'(len / 2), periodCount);
      chk("pulseTotal", expTotal, pulseTotal);
    end
  endtask

  // reset, then every scenario in turn
  initial begin
    repeat (4) @(negedge clk);
    resetn = 1'b1;
    repeat (3) @(negedge clk);
    ce = 1'b1;
    chk("pulseTotal", 32'h0, pulseTotal);
    chk("periodCount", 32'h0, periodCount);
    t_status();
    t_modes();
    t_quad();
    t_preset();
    t_range();
    t_window();
    give_verdict();
  end
endmodule

`default_nettype wire
